// file: verilog/srs_pkg.sv
// Constants, states and timing counts of the system reset sequencer.
// Functional notes
// - Five reset sources, each with own flag.
// - Low input beyond 1040 units: long reset.
// - Low up to 1038 units, sense high: short.
// - Long reset forces default state at once.
// - Sense pin level during pulse picks mode.
// - Synchronous entry settles within 12 units.
// - Enabled bidirectional mode pulls input pin low.
// - Bidirectional enable cleared on every reset.
// - Internal sequence 1024 units, then sample input.
// - Input still low extends into long reset.
// - Sense level at release picks exit mode.
// - Latch configuration 8 units, 6 if bypassed.
// - External fetch: strobes inactive at latch time.
// - Execution starts at address zero, segment zero.
// - Sense drop: no pull-down, asynchronous handling.
// - Asynchronous reset detected without a clock.
// - Software reset instruction accepted only in run state.
// - Software reset latches bits 12..6, clears 5..2.
// - Reset output low until end of initialization.
// - Source flags kept; all but watchdog cleared by end of initialization.
// - Bidirectional enable settable only before initialization end.
package srs_pkg;

	// ==========================================================
	// Timing, in half-clock units, and derived CPU clock counts.
	// ==========================================================
	localparam int UNITS_PER_CLK    = 2;
	localparam int DETECT_UNITS     = 4;
	localparam int SETTLE_UNITS     = 12;
	localparam int SEQ_UNITS        = 1024;
	localparam int LONG_UNITS       = 1040;
	localparam int SHORT_MAX_UNITS  = 1038;
	localparam int LATCH_UNITS      = 8;
	localparam int LATCH_BYP_UNITS  = 6;

	localparam logic [1:0]  DETECT_CLKS    = 2'(DETECT_UNITS / UNITS_PER_CLK);
	localparam logic [2:0]  SETTLE_CLKS    = 3'(SETTLE_UNITS / UNITS_PER_CLK);
	localparam logic [9:0]  SEQ_CLKS       = 10'(SEQ_UNITS / UNITS_PER_CLK);
	localparam logic [9:0]  LONG_CLKS      = 10'(LONG_UNITS / UNITS_PER_CLK);
	localparam logic [9:0]  SHORT_MAX_CLKS = 10'(SHORT_MAX_UNITS / UNITS_PER_CLK);
	localparam logic [3:0]  LATCH_CLKS     = 4'(LATCH_UNITS / UNITS_PER_CLK);
	localparam logic [3:0]  LATCH_BYP_CLKS = 4'(LATCH_BYP_UNITS / UNITS_PER_CLK);

	// ==========================================================
	// Configuration field layout and reset values.
	// ==========================================================
	localparam int          CFG_W          = 16;
	localparam int          CFG_SW_HI      = 12;
	localparam int          CFG_SW_LO      = 6;
	localparam int          CFG_CLR_HI     = 5;
	localparam int          CFG_CLR_LO     = 2;
	localparam logic [15:0] CFG_RESET      = 16'hffff;
	localparam logic [15:0] CFG_SW_MASK    = 16'h1fc0;
	localparam logic [15:0] CFG_CLR_MASK   = 16'h003c;
	localparam logic [23:0] RESET_VECTOR   = 24'h000000;
	localparam logic [7:0]  RESET_SEGMENT  = 8'h00;

	// Source flag positions.
	localparam int FLAG_WDT  = 0;
	localparam int FLAG_SW   = 1;
	localparam int FLAG_SHW  = 2;
	localparam int FLAG_LHW  = 3;
	localparam int FLAG_PON  = 4;
	localparam int FLAG_W    = 5;
	localparam logic [4:0] FLAGS_RESET = 5'h1f;

	typedef enum logic [2:0] {
		ST_RUN    = 3'b000,
		ST_SETTLE = 3'b001,
		ST_SEQ    = 3'b010,
		ST_EXTEND = 3'b011,
		ST_LATCH  = 3'b100
	} srs_state_e;

endpackage : srs_pkg

// file: verilog/srs_counter.sv
// Loadable down counter with a zero flag, used for each sequencer delay.
`timescale 1ns/1ps
module srs_counter
	import srs_pkg::*;
#(
	parameter int W = 10
)
(
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic         load,
	input  wire logic [W-1:0] value,
	output logic              zero
);
	logic [W-1:0] count_reg;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			count_reg <= '0;
		else if (load)
			count_reg <= value;
		else if (count_reg != '0)
			count_reg <= count_reg - W'(1);
	end

	assign zero = (count_reg == '0) && !load;

endmodule : srs_counter

// file: verilog/srs_pulse_meter.sv
// Measures the length of a low pulse on the synchronous reset input.
`timescale 1ns/1ps
module srs_pulse_meter
	import srs_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       reset_input_n,
	output logic            detected,
	output logic            is_long
);
	logic [9:0] low_cnt_reg;

	// ==========================================================
	// Saturating low-time counter in CPU clocks.
	// ==========================================================
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			low_cnt_reg <= '0;
		else if (reset_input_n)
			low_cnt_reg <= '0;
		else if (low_cnt_reg != 10'h3ff)
			low_cnt_reg <= low_cnt_reg + 10'h001;
	end

	// Shorter glitches are not a reset.
	assign detected = !reset_input_n && (low_cnt_reg + 10'h001 >= 10'(DETECT_CLKS));
	// Over 1040 units is long; the 1038..1040 gap counts as short here.
	assign is_long  = (low_cnt_reg > LONG_CLKS);

endmodule : srs_pulse_meter

// file: verilog/srs_sequencer.sv
// System reset sequencer: source classification, internal sequence and start-up latch.
`timescale 1ns/1ps
module srs_sequencer
	import srs_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic              reset_input_n,
	input  wire logic              reset_mode_sense,
	input  wire logic              watchdog_overflow,
	input  wire logic              soft_reset_instr,
	input  wire logic              end_of_init_instr,
	input  wire logic              bidir_enable_wr,
	input  wire logic              bidir_enable_wdata,
	input  wire logic              pll_bypass_prescale,
	input  wire logic              external_fetch,
	input  wire logic [CFG_W-1:0]  startup_config_pins,
	output logic                   reset_output_n,
	output logic                   reset_input_pd_out,
	output logic                   reset_input_pd_oe,
	output logic                   bidir_reset_enable,
	output logic                   bus_hold_cancel,
	output logic                   bus_abort,
	output logic                   io_tristate,
	output logic                   config_pullup,
	output logic                   strobes_inactive,
	output logic                   cpu_start,
	output logic [23:0]            start_address,
	output logic [7:0]             start_segment,
	output logic                   async_mode,
	output logic [CFG_W-1:0]       system_config_reg,
	output logic                   poweron_reset_flag,
	output logic                   long_hw_reset_flag,
	output logic                   short_hw_reset_flag,
	output logic                   watchdog_reset_flag,
	output logic                   soft_reset_flag
);
	// ==========================================================
	// State and delays.
	// ==========================================================
	srs_state_e state_reg;
	srs_state_e state_next;
	logic       detected;
	logic       is_long;
	logic       settle_zero;
	logic       seq_zero;
	logic       latch_zero;
	logic       soft_src_reg;
	logic       sense_low_seen_reg;
	logic       in_reset_reg;
	logic       pd_active;
	logic       start_reset;

	srs_pulse_meter u_meter (
		.ref_clk       (ref_clk),
		.rst           (rst),
		.reset_input_n (reset_input_n),
		.detected      (detected),
		.is_long       (is_long)
	);

	srs_counter #(.W(3)) u_settle (
		.ref_clk (ref_clk),
		.rst     (rst),
		.load    (start_reset),
		.value   (SETTLE_CLKS),
		.zero    (settle_zero)
	);

	srs_counter #(.W(10)) u_seq (
		.ref_clk (ref_clk),
		.rst     (rst),
		.load    (state_reg == ST_SETTLE && settle_zero),
		.value   (SEQ_CLKS),
		.zero    (seq_zero)
	);

	srs_counter #(.W(4)) u_latch (
		.ref_clk (ref_clk),
		.rst     (rst),
		.load    (state_next == ST_LATCH && state_reg != ST_LATCH),
		.value   (pll_bypass_prescale ? LATCH_BYP_CLKS : LATCH_CLKS),
		.zero    (latch_zero)
	);

	// Hardware detection, watchdog and the protected instruction restart
	// the sequence, only from run state; soft reset is ignored during a sequence.
	assign start_reset = (state_reg == ST_RUN) &&
		(detected || watchdog_overflow || soft_reset_instr);

	// Pull-down only while enabled, in the sequence, and the sense level holds.
	assign pd_active = bidir_reset_enable && (state_reg == ST_SETTLE || state_reg == ST_SEQ)
		&& reset_mode_sense;

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ST_RUN:
				if (start_reset)
					state_next = ST_SETTLE;
			ST_SETTLE:
				if (settle_zero)
					state_next = ST_SEQ;
			// Our own pull-down is let go for one cycle before the pin is read.
			ST_SEQ:
				if (seq_zero && !reset_input_pd_oe)
					state_next = reset_input_n ? ST_LATCH : ST_EXTEND;
			ST_EXTEND:
				if (reset_input_n)
					state_next = ST_LATCH;
			ST_LATCH:
				if (latch_zero)
					state_next = ST_RUN;
			default:
				state_next = ST_RUN;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			state_reg <= ST_SETTLE;
		else
			state_reg <= state_next;
	end

	// ==========================================================
	// Mode selection from the sense pin.
	// ==========================================================
	// Any low sense level in the pulse makes it asynchronous; the level at
	// release decides the exit mode. Power-on starts asynchronous.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			sense_low_seen_reg <= 1'b1;
		else if (start_reset)
			sense_low_seen_reg <= !reset_mode_sense;
		else if (state_reg != ST_RUN && !reset_mode_sense)
			sense_low_seen_reg <= 1'b1;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			async_mode <= 1'b1;
		else if (state_reg == ST_EXTEND && reset_input_n)
			async_mode <= !reset_mode_sense;
		else if (state_reg != ST_RUN && state_reg != ST_LATCH)
			async_mode <= sense_low_seen_reg || !reset_mode_sense;
	end

	// ==========================================================
	// Reset default state and bus handling.
	// ==========================================================
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			in_reset_reg <= 1'b1;
		else
			in_reset_reg <= (state_next != ST_RUN);
	end

	// The asynchronous reset itself forces the default state without any clock edge.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			bus_hold_cancel <= 1'b1;
			bus_abort       <= 1'b1;
			io_tristate     <= 1'b1;
			config_pullup   <= 1'b1;
		end
		else
		begin
			bus_hold_cancel <= (state_next == ST_SETTLE);
			bus_abort       <= (state_next == ST_SETTLE) && !watchdog_overflow;
			io_tristate     <= (state_next != ST_RUN);
			config_pullup   <= (state_next != ST_RUN);
		end
	end

	// Held low past the sequence until the end of initialization.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			reset_output_n <= 1'b0;
		else if (state_next == ST_SETTLE)
			reset_output_n <= 1'b0;
		else if (end_of_init_instr && state_reg == ST_RUN)
			reset_output_n <= 1'b1;
	end

	// ==========================================================
	// Bidirectional reset pin.
	// ==========================================================
	// A drop of the sense level outside run state clears the enable before the next cycle.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			bidir_reset_enable <= 1'b0;
		else if (state_reg == ST_SEQ && seq_zero)
			bidir_reset_enable <= 1'b0;
		else if (state_reg != ST_RUN && !reset_mode_sense)
			bidir_reset_enable <= 1'b0;
		else if (bidir_enable_wr && state_reg == ST_RUN && !reset_output_n)
			bidir_reset_enable <= bidir_enable_wdata;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			reset_input_pd_out <= 1'b0;
			reset_input_pd_oe  <= 1'b0;
		end
		else
		begin
			reset_input_pd_out <= 1'b0;
			reset_input_pd_oe  <= pd_active && !(state_reg == ST_SEQ && seq_zero);
		end
	end

	// ==========================================================
	// Source flags.
	// ==========================================================
	// Softer sources are implied by harder ones; a new event wins over a clear.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			soft_src_reg <= 1'b0;
		else if (start_reset)
			soft_src_reg <= !detected;
		else if (state_reg == ST_EXTEND)
			soft_src_reg <= 1'b0;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			poweron_reset_flag  <= 1'b1;
			long_hw_reset_flag  <= 1'b1;
			short_hw_reset_flag <= 1'b1;
			soft_reset_flag     <= 1'b1;
			watchdog_reset_flag <= 1'b0;
		end
		else if (start_reset)
		begin
			soft_reset_flag <= 1'b1;
			if (detected)
				short_hw_reset_flag <= 1'b1;
			if (watchdog_overflow && !detected)
				watchdog_reset_flag <= 1'b1;
		end
		else if (state_reg == ST_EXTEND || (state_reg != ST_RUN && is_long))
		begin
			long_hw_reset_flag  <= 1'b1;
			short_hw_reset_flag <= 1'b1;
			soft_reset_flag     <= 1'b1;
		end
		else if (end_of_init_instr && state_reg == ST_RUN)
		begin
			poweron_reset_flag  <= 1'b0;
			long_hw_reset_flag  <= 1'b0;
			short_hw_reset_flag <= 1'b0;
			soft_reset_flag     <= 1'b0;
		end
	end

	// ==========================================================
	// Configuration latch and start of execution.
	// ==========================================================
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			system_config_reg <= CFG_RESET;
		else if (state_reg == ST_LATCH && latch_zero)
		begin
			if (soft_src_reg)
				system_config_reg <= (system_config_reg & ~(CFG_SW_MASK | CFG_CLR_MASK))
					| (startup_config_pins & CFG_SW_MASK);
			else
				system_config_reg <= startup_config_pins;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			strobes_inactive <= 1'b0;
			cpu_start        <= 1'b0;
			start_address    <= RESET_VECTOR;
			start_segment    <= RESET_SEGMENT;
		end
		else
		begin
			strobes_inactive <= (state_reg == ST_LATCH && latch_zero && external_fetch);
			cpu_start        <= (state_reg == ST_LATCH && latch_zero);
			start_address    <= RESET_VECTOR;
			start_segment    <= RESET_SEGMENT;
		end
	end

	// Unused reference kept small: in_reset_reg mirrors the sequence for io_tristate timing.
	logic unused_ok;
	assign unused_ok = in_reset_reg;

endmodule : srs_sequencer

// file: bench/srs_reset_circuit.sv
// Model of the external circuit that drives the reset input and mode sense pins.
`timescale 1ns/1ps
module srs_reset_circuit
(
	input  wire logic ref_clk,
	input  wire logic reset_input_pd_oe,
	input  wire logic reset_input_pd_out,
	output logic      reset_input_n,
	output logic      reset_mode_sense
);
	logic ext_low_reg;
	// The pin has a pull-up, so it reads high unless one side pulls it low.
	assign reset_input_n = !(ext_low_reg || (reset_input_pd_oe && !reset_input_pd_out));
	initial
	begin
		ext_low_reg = 1'b1;
		reset_mode_sense = 1'b0;
	end
	// The sense pin stays low so that power-on completes as asynchronous.
	task automatic release_power();
		@(posedge ref_clk);
		ext_low_reg <= 1'b0;
	endtask : release_power
	// Lets the sense level rise, as a charged capacitor would after power-on.
	task automatic set_sense(input logic sense);
		@(posedge ref_clk);
		reset_mode_sense <= sense;
	endtask : set_sense
	task automatic hold_low(input int clks, input logic sense);
		@(posedge ref_clk);
		ext_low_reg <= 1'b1;
		reset_mode_sense <= sense;
		repeat ((clks < 2) ? 2 : clks) @(posedge ref_clk);
		ext_low_reg <= 1'b0;
	endtask : hold_low
endmodule : srs_reset_circuit

// file: bench/srs_sequencer_monitor.sv
// Concurrent checks on the ports of the reset sequencer.
`timescale 1ns/1ps
module srs_sequencer_monitor
	import srs_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        reset_input_n,
	input wire logic        end_of_init_instr,
	input wire logic        watchdog_overflow,
	input wire logic        external_fetch,
	input wire logic        reset_output_n,
	input wire logic        reset_input_pd_out,
	input wire logic        reset_input_pd_oe,
	input wire logic        bidir_reset_enable,
	input wire logic        bus_hold_cancel,
	input wire logic        bus_abort,
	input wire logic        io_tristate,
	input wire logic        config_pullup,
	input wire logic        strobes_inactive,
	input wire logic        cpu_start,
	input wire logic [23:0] start_address,
	input wire logic [7:0]  start_segment,
	input wire logic        poweron_reset_flag,
	input wire logic        long_hw_reset_flag,
	input wire logic        short_hw_reset_flag,
	input wire logic        soft_reset_flag
);
	// ====================
	// Cycles since the reset output went low.
	// ====================
	logic [10:0] low_cnt_reg;
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			low_cnt_reg <= 11'h000;
		else if (reset_output_n)
			low_cnt_reg <= 11'h000;
		else if (low_cnt_reg != 11'h7ff)
			low_cnt_reg <= low_cnt_reg + 11'h001;
	end
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	a_detect_low: assert property ((reset_output_n && !reset_input_n)[*2] |-> ##[0:2] !reset_output_n)
		else $error("reset input low not answered");
	a_default_state: assert property ($fell(reset_output_n) |-> io_tristate && (bus_abort || $past(watchdog_overflow)) && bus_hold_cancel && config_pullup)
		else $error("default state missing at reset entry");
	a_pd_in_reset: assert property (reset_input_pd_oe |-> !reset_output_n && !reset_input_pd_out)
		else $error("pull-down outside a reset");
	a_seq_length: assert property (cpu_start |-> low_cnt_reg >= 11'h206)
		else $error("start came before the full sequence");
	a_start_vector: assert property (cpu_start |-> start_address == RESET_VECTOR && start_segment == RESET_SEGMENT)
		else $error("start location not zero");
	a_strobe_fetch: assert property (strobes_inactive |-> external_fetch)
		else $error("strobes forced without external fetch");
	a_bidir_cleared: assert property (cpu_start |-> !bidir_reset_enable)
		else $error("bidirectional enable survived the reset");
	a_bidir_init_only: assert property ($rose(bidir_reset_enable) |-> !reset_output_n)
		else $error("bidirectional enable set after initialization");
	a_reset_output_n_hold: assert property ($rose(reset_output_n) |-> $past(end_of_init_instr))
		else $error("reset output released without end of initialization");
	a_flags_clear: assert property ($rose(reset_output_n) |-> !(poweron_reset_flag || long_hw_reset_flag || short_hw_reset_flag || soft_reset_flag))
		else $error("source flags not cleared");
endmodule : srs_sequencer_monitor
bind srs_sequencer srs_sequencer_monitor u_mon (.ref_clk, .rst, .reset_input_n,
	.end_of_init_instr, .watchdog_overflow, .external_fetch, .reset_output_n, .reset_input_pd_out,
	.reset_input_pd_oe, .bidir_reset_enable, .bus_hold_cancel, .bus_abort, .io_tristate,
	.config_pullup, .strobes_inactive, .cpu_start, .start_address, .start_segment,
	.poweron_reset_flag, .long_hw_reset_flag, .short_hw_reset_flag, .soft_reset_flag);

// file: bench/system_reset_sequencer_test.sv
// Self-checking bench for the system reset sequencer.
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
	$display("mismatch at %0t got %h expected %h", $time, (a), (e)); end end
module system_reset_sequencer_test
	import srs_pkg::*;
;
	logic ref_clk, rst, reset_input_n, reset_mode_sense, watchdog_overflow, soft_reset_instr;
	logic end_of_init_instr, bidir_enable_wr, bidir_enable_wdata, pll_bypass_prescale;
	logic external_fetch, reset_output_n, reset_input_pd_out, reset_input_pd_oe;
	logic bidir_reset_enable, strobes_inactive, cpu_start, async_mode;
	logic poweron_reset_flag, long_hw_reset_flag, short_hw_reset_flag;
	logic watchdog_reset_flag, soft_reset_flag, saw_pd, saw_strobe;
	logic [15:0] startup_config_pins, system_config_reg, exp_cfg;
	logic [23:0] start_address;
	logic [7:0]  start_segment;
	int num_errors, cmp_count, cycles, n_a, n_b;
	srs_sequencer uut (.ref_clk, .rst, .reset_input_n, .reset_mode_sense, .watchdog_overflow,
		.soft_reset_instr, .end_of_init_instr, .bidir_enable_wr, .bidir_enable_wdata,
		.pll_bypass_prescale, .external_fetch, .startup_config_pins, .reset_output_n,
		.reset_input_pd_out, .reset_input_pd_oe, .bidir_reset_enable, .bus_hold_cancel(),
		.bus_abort(), .io_tristate(), .config_pullup(), .strobes_inactive, .cpu_start,
		.start_address, .start_segment, .async_mode, .system_config_reg, .poweron_reset_flag,
		.long_hw_reset_flag, .short_hw_reset_flag, .watchdog_reset_flag, .soft_reset_flag);
	srs_reset_circuit u_far (.ref_clk, .reset_input_pd_oe, .reset_input_pd_out,
		.reset_input_n, .reset_mode_sense);
	// ====================
	// Shared tasks.
	// ====================
	task automatic conclude();
		$display("checks %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude
	// Pulse one request input for a single cycle: 0 end of init, 1 soft, 2 watchdog, 3 write.
	task automatic strobe(input int which);
		@(posedge ref_clk);
		end_of_init_instr <= (which == 0);
		soft_reset_instr <= (which == 1);
		watchdog_overflow <= (which == 2);
		bidir_enable_wr <= (which == 3);
		@(posedge ref_clk);
		{end_of_init_instr, soft_reset_instr, watchdog_overflow, bidir_enable_wr} <= 4'h0;
		@(negedge ref_clk);
	endtask : strobe
	task automatic wait_start(output int n);
		n = 0;
		saw_pd = 1'b0;
		saw_strobe = 1'b0;
		while (cpu_start !== 1'b1 && n < 3000)
		begin
			@(posedge ref_clk);
			n++;
			saw_pd |= (reset_input_pd_oe === 1'b1);
			saw_strobe |= (strobes_inactive === 1'b1);
		end
		@(posedge ref_clk);
		saw_strobe |= (strobes_inactive === 1'b1);
		if (n >= 3000)
			num_errors++;
	endtask : wait_start
	task automatic end_init();
		strobe(0);
		repeat (2) @(posedge ref_clk);
		`CHK(reset_output_n, 1'b1)
		`CHK({poweron_reset_flag, long_hw_reset_flag, short_hw_reset_flag, soft_reset_flag}, 4'h0)
	endtask : end_init
	// ====================
	// Scenarios.
	// ====================
	task automatic t_power_on();
		`CHK({poweron_reset_flag, watchdog_reset_flag}, 2'b10)
		wait_start(n_a);
		`CHK(system_config_reg, exp_cfg)
		`CHK({start_segment, start_address}, 32'h00000000)
		`CHK({async_mode, reset_output_n}, 2'b10)
		bidir_enable_wdata <= 1'b1;
		strobe(3);
		`CHK(bidir_reset_enable, 1'b1)
		end_init();
		bidir_enable_wdata <= 1'b0;
		strobe(3);
		`CHK(bidir_reset_enable, 1'b1)
	endtask : t_power_on
	task automatic t_internal(input int which);
		startup_config_pins <= 16'ha5c3 ^ 16'(which);
		strobe(which);
		wait_start(n_a);
		exp_cfg = (exp_cfg & ~(CFG_SW_MASK | CFG_CLR_MASK)) | (startup_config_pins & CFG_SW_MASK);
		`CHK(system_config_reg, exp_cfg)
		`CHK({soft_reset_flag, watchdog_reset_flag}, (which == 1) ? 2'b10 : 2'b11)
		`CHK(bidir_reset_enable, 1'b0)
		`CHK(saw_pd, which == 1)
		end_init();
	endtask : t_internal
	task automatic t_hw(input int clks, input logic sense, input logic byp, output int n);
		pll_bypass_prescale <= byp;
		external_fetch <= byp;
		startup_config_pins <= 16'h3c00 ^ 16'(clks);
		u_far.hold_low(clks, sense);
		wait_start(n);
		exp_cfg = startup_config_pins;
		`CHK(system_config_reg, exp_cfg)
		`CHK({long_hw_reset_flag, short_hw_reset_flag}, (clks > 520) ? 2'b11 : 2'b01)
		`CHK(async_mode, !sense)
		`CHK(saw_strobe, byp)
		end_init();
	endtask : t_hw
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			num_errors++;
			conclude();
		end
	end
	initial
	begin
		{rst, watchdog_overflow, soft_reset_instr, end_of_init_instr} = 4'h8;
		{bidir_enable_wr, bidir_enable_wdata, pll_bypass_prescale, external_fetch} = 4'h0;
		startup_config_pins = 16'h1234;
		exp_cfg = 16'h1234;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		u_far.release_power();
		t_power_on();
		u_far.set_sense(1'b1);
		t_internal(1);
		t_internal(2);
		t_hw(10, 1'b1, 1'b0, n_a);
		t_hw(600, 1'b0, 1'b0, n_a);
		t_hw(600, 1'b1, 1'b1, n_b);
		`CHK(n_a - n_b, 32'(LATCH_CLKS) - 32'(LATCH_BYP_CLKS))
		conclude();
	end
endmodule : system_reset_sequencer_test
